// [hw/acr_adc_control_regs.sv]
// converter control and result registers with sar sequencer
// assumes an axi4-lite master, a comparator and a 12-bit dac
`include "acr_params.svh"

module acr_adc_control_regs
(
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write address
  input  wire logic [31:0]            awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   awvalid,
  output logic                        awready,
  // axi4-lite write data
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  // axi4-lite write response
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  // axi4-lite read address
  input  wire logic [31:0]            araddr,
  input  wire logic [2:0]             arprot,
  input  wire logic                   arvalid,
  output logic                        arready,
  // axi4-lite read data
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // analog front end
  input  wire logic                   cmp_above,
  output logic [11:0]                 dac_code,
  output logic                        sample_hold,
  output logic                        busy,
  output acr_pkg::acr_mux_t           input_switch,
  output logic                        ref_from_bandgap,
  output logic [1:0]                  bandgap_level
);

  // ****************************************************
  // declarations
  // ****************************************************
  acr_pkg::acr_cfg_t   cfg_q;
  acr_pkg::acr_state_t state_q;
  logic                start_q;
  logic [11:0]         result_q;
  logic [11:0]         sar_q;
  logic [3:0]          bit_idx_q;
  logic [2:0]          sample_cnt_q;
  logic                conv_tick;
  logic                conv_done;
  logic [11:0]         sar_final;

  logic                awready_q;
  logic                wready_q;
  logic                aw_full_q;
  logic                w_full_q;
  logic [11:0]         waddr_q;
  logic [7:0]          wbyte_q;
  logic                wlane_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                arready_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic                wr_fire;
  logic                wr_ctl;
  logic                wr_sel;
  logic                wr_hit;
  logic [11:0]         raddr;
  logic [7:0]          rbyte;
  logic                rd_hit;

  // ****************************************************
  // write channel capture
  // ****************************************************
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
      waddr_q   <= 12'h000;
    end
    else if (awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      waddr_q   <= awaddr[`ACR_ADDR_W-1:0];
    end
    else if (wr_fire)
    begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
      wbyte_q  <= 8'h00;
      wlane_q  <= 1'b0;
    end
    else if (wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wbyte_q  <= wdata[7:0];
      wlane_q  <= wstrb[0];
    end
    else if (wr_fire)
    begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
    end
  end

  // ****************************************************
  // write decode and response
  // ****************************************************
  assign wr_ctl = wr_fire && wlane_q && (waddr_q == `ACR_ADDR_CONTROL);
  assign wr_sel = wr_fire && wlane_q && (waddr_q == `ACR_ADDR_SELECT);
  assign wr_hit = (waddr_q == `ACR_ADDR_CONTROL)
               || (waddr_q == `ACR_ADDR_SELECT)
               || (waddr_q == `ACR_ADDR_RESULT_HIGH);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `ACR_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  // ****************************************************
  // configuration registers
  // ****************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_q.clk_div <= `ACR_RST_DIV;
    else if (wr_ctl)
      cfg_q.clk_div <= wbyte_q[`ACR_CTL_DIV_MSB:`ACR_CTL_DIV_LSB];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q.ref_sel  <= `ACR_RST_REF;
      cfg_q.chan_sel <= `ACR_RST_CHAN;
    end
    else if (wr_sel)
    begin
      cfg_q.ref_sel  <= wbyte_q[`ACR_SEL_REF_MSB:`ACR_SEL_REF_LSB];
      cfg_q.chan_sel <= wbyte_q[`ACR_SEL_CHAN_MSB:`ACR_SEL_CHAN_LSB];
    end
  end

  // ****************************************************
  // start bit
  // ****************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start_q <= 1'b0;
    else if (wr_ctl && wbyte_q[`ACR_CTL_START_BIT])
      start_q <= 1'b1;
    else if (conv_done)
      start_q <= 1'b0;
  end

  // ****************************************************
  // reference decode
  // ****************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_from_bandgap <= 1'b0;
      bandgap_level    <= `ACR_REF_VCC;
    end
    else
    begin
      ref_from_bandgap <= (cfg_q.ref_sel == `ACR_REF_BG_248)
                       || (cfg_q.ref_sel == `ACR_REF_BG_200);
      if ((cfg_q.ref_sel == `ACR_REF_BG_248)
       || (cfg_q.ref_sel == `ACR_REF_BG_200))
        bandgap_level <= cfg_q.ref_sel;
      else
        bandgap_level <= `ACR_REF_VCC;
    end
  end

  // ****************************************************
  // conversion clock and input switches
  // ****************************************************
  acr_clk_div u_clk_div
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (state_q != acr_pkg::ACR_IDLE),
    .div_sel (cfg_q.clk_div),
    .tick_q  (conv_tick)
  );

  acr_chan_decode u_chan_decode
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .chan_sel (cfg_q.chan_sel),
    .mux_q    (input_switch)
  );

  // ****************************************************
  // successive approximation sequencer
  // ****************************************************
  assign conv_done = (state_q == acr_pkg::ACR_CONVERT) && conv_tick
                  && (bit_idx_q == 4'h0);

  always_comb
  begin
    sar_final = sar_q;
    if (!cmp_above)
      sar_final[bit_idx_q] = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q      <= acr_pkg::ACR_IDLE;
      sar_q        <= 12'h000;
      bit_idx_q    <= 4'h0;
      sample_cnt_q <= 3'h0;
    end
    else
    begin
      unique case (state_q)
        acr_pkg::ACR_IDLE:
        begin
          if (start_q)
          begin
            state_q      <= acr_pkg::ACR_SAMPLE;
            sample_cnt_q <= 3'h0;
          end
        end
        acr_pkg::ACR_SAMPLE:
        begin
          if (conv_tick)
          begin
            if (sample_cnt_q == `ACR_SAMPLE_TICKS - 3'h1)
            begin
              state_q   <= acr_pkg::ACR_CONVERT;
              sar_q     <= 12'h800;
              bit_idx_q <= `ACR_RESULT_MSB;
            end
            else
              sample_cnt_q <= sample_cnt_q + 3'h1;
          end
        end
        acr_pkg::ACR_CONVERT:
        begin
          if (conv_tick)
          begin
            sar_q <= sar_final;
            if (bit_idx_q == 4'h0)
              state_q <= acr_pkg::ACR_IDLE;
            else
            begin
              sar_q[bit_idx_q - 4'h1] <= 1'b1;
              bit_idx_q               <= bit_idx_q - 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_q <= `ACR_RST_RESULT;
    else if (conv_done)
      result_q <= sar_final;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample_hold <= 1'b0;
      busy        <= 1'b0;
    end
    else
    begin
      sample_hold <= (state_q == acr_pkg::ACR_SAMPLE);
      busy        <= (state_q != acr_pkg::ACR_IDLE);
    end
  end

  // ****************************************************
  // read channel
  // ****************************************************
  assign raddr  = araddr[`ACR_ADDR_W-1:0];
  assign rd_hit = (raddr == `ACR_ADDR_CONTROL)
               || (raddr == `ACR_ADDR_SELECT)
               || (raddr == `ACR_ADDR_RESULT_HIGH);

  always_comb
  begin
    rbyte = 8'h00;
    if (raddr == `ACR_ADDR_RESULT_HIGH)
      rbyte = result_q[11:4];
    else if (raddr == `ACR_ADDR_CONTROL)
      rbyte = {result_q[3:0], start_q, cfg_q.clk_div};
    else if (raddr == `ACR_ADDR_SELECT)
      rbyte = {cfg_q.ref_sel, 1'b0, cfg_q.chan_sel};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `ACR_RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rbyte};
      rresp_q   <= rd_hit ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
    end
    else if (rvalid_q && rready)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ****************************************************
  // output wiring
  // ****************************************************
  assign awready  = awready_q;
  assign wready   = wready_q;
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign arready  = arready_q;
  assign rvalid   = rvalid_q;
  assign rdata    = rdata_q;
  assign rresp    = rresp_q;
  assign dac_code = sar_q;

endmodule

// [hw/acr_chan_decode.sv]
// input selector decode into analog switch enables
// assumes the switches are driven straight from these flops
`include "acr_params.svh"

module acr_chan_decode
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // selector code
  input  wire logic [4:0]       chan_sel,
  // switch enables
  output acr_pkg::acr_mux_t     mux_q
);

  acr_pkg::acr_mux_t mux_d;

  // ****************************************************
  // one switch per external pin
  // ****************************************************
  genvar i;
  generate
    for (i = 0; i <= `ACR_CHAN_LAST_PIN; i++)
    begin : g_pin
      assign mux_d.pin_en[i] = (chan_sel == 5'(i));
    end
  endgenerate

  assign mux_d.bandgap_en     = (chan_sel == `ACR_CHAN_BANDGAP);
  assign mux_d.quarter_vcc_en = (chan_sel == `ACR_CHAN_QUARTER_VCC);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mux_q <= '0;
    else
      mux_q <= mux_d;
  end

endmodule

// [hw/acr_clk_div.sv]
// conversion clock tick generator
// assumes run is held high for the whole of a conversion
`include "acr_params.svh"

module acr_clk_div
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  // tick out
  output logic            tick_q
);

  logic [7:0] cnt_q;
  logic [7:0] term;

  // ****************************************************
  // divide by 256 shifted right by the select code
  // ****************************************************
  // divider terminal count
  assign term = `ACR_DIV_MAX_TERM >> div_sel;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end
    else if (cnt_q >= term)
    begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

endmodule

// [hw/acr_params.svh]
// constants for the converter control register block
// assumes a 32-bit axi4-lite bus and a 200 mhz system clock
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ****************************************************
// register indices and byte addresses
// ****************************************************
`define ACR_IDX_RESULT_HIGH   8'h17
`define ACR_IDX_CONTROL       8'h18
`define ACR_IDX_SELECT        8'h19
`define ACR_ADDR_RESULT_HIGH  {2'h0, `ACR_IDX_RESULT_HIGH, 2'h0}
`define ACR_ADDR_CONTROL      {2'h0, `ACR_IDX_CONTROL, 2'h0}
`define ACR_ADDR_SELECT       {2'h0, `ACR_IDX_SELECT, 2'h0}
`define ACR_ADDR_W            12

// ****************************************************
// field positions
// ****************************************************
`define ACR_CTL_LOW_MSB       7
`define ACR_CTL_LOW_LSB       4
`define ACR_CTL_START_BIT     3
`define ACR_CTL_DIV_MSB       2
`define ACR_CTL_DIV_LSB       0
`define ACR_SEL_REF_MSB       7
`define ACR_SEL_REF_LSB       6
`define ACR_SEL_CHAN_MSB      4
`define ACR_SEL_CHAN_LSB      0

// ****************************************************
// reset values and codes
// ****************************************************
`define ACR_RST_DIV           3'h0
`define ACR_RST_REF           2'h0
`define ACR_RST_CHAN          5'h1f
`define ACR_RST_RESULT        12'h000
`define ACR_CHAN_LAST_PIN     12
`define ACR_CHAN_BANDGAP      5'h0e
`define ACR_CHAN_QUARTER_VCC  5'h17
`define ACR_REF_VCC           2'h0
`define ACR_REF_BG_248        2'h1
`define ACR_REF_BG_200        2'h3
`define ACR_DIV_MAX_TERM      8'hff

// ****************************************************
// sample length in conversion clock ticks and the result msb index
// ****************************************************
`define ACR_SAMPLE_TICKS      3'h4
`define ACR_RESULT_MSB        4'hb

// ****************************************************
// axi responses
// ****************************************************
`define ACR_RESP_OKAY         2'h0
`define ACR_RESP_SLVERR       2'h2

`endif

// [hw/acr_pkg.sv]
// types shared by the converter control register block
// assumes acr_params.svh supplies all numeric constants
package acr_pkg;

  // ****************************************************
  // configuration carried to the converter
  // ****************************************************
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [4:0] chan_sel;
    logic [2:0] clk_div;
  } acr_cfg_t;

  // ****************************************************
  // analog input switch enables
  // ****************************************************
  typedef struct packed {
    logic [12:0] pin_en;
    logic        bandgap_en;
    logic        quarter_vcc_en;
  } acr_mux_t;

  // ****************************************************
  // conversion sequencer states
  // ****************************************************
  typedef enum logic [1:0] {
    ACR_IDLE,
    ACR_SAMPLE,
    ACR_CONVERT
  } acr_state_t;

endpackage

// [sim/acr_adc_control_regs_assertions.sv]
// port checker for the converter control register block
// assumes it is bound to acr_adc_control_regs
`include "acr_params.svh"

module acr_adc_control_regs_assertions
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus
  input wire logic [31:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [31:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // analog side
  input wire logic        sample_hold,
  input wire acr_pkg::acr_mux_t input_switch,
  input wire logic        ref_from_bandgap,
  input wire logic [1:0]  bandgap_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic mapped(input logic [31:0] a);
    return a[11:0] inside {`ACR_ADDR_RESULT_HIGH, `ACR_ADDR_CONTROL,
                           `ACR_ADDR_SELECT};
  endfunction

  // ****************************************************
  // assertions
  // ****************************************************
  AST_SWITCH_ONEHOT: assert property (
    $onehot0(input_switch)) else $error("switch not one-hot");
  AST_LEVEL_DECODE: assert property (
    bandgap_level != 2'h2 && ref_from_bandgap == (bandgap_level != 2'h0))
    else $error("reference decode mismatch");
  AST_BVALID_HOLD: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_RVALID_HOLD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  AST_RDATA_HIGH: assert property (
    rvalid |-> rdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_RD_SLVERR: assert property (
    arvalid && arready && !mapped(araddr) |=>
      rvalid && rresp == `ACR_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_WR_OKAY: assert property (
    awvalid && awready && wvalid && wready && mapped(awaddr) |->
      ##[1:2] (bvalid && bresp == `ACR_RESP_OKAY))
    else $error("mapped write not answered");
  AST_WR_SLVERR: assert property (
    awvalid && awready && wvalid && wready && !mapped(awaddr) |->
      ##[1:2] (bvalid && bresp == `ACR_RESP_SLVERR))
    else $error("unmapped write not refused");
  AST_AR_BLOCK: assert property (
    rvalid |-> !arready) else $error("read accepted while answering");
  AST_SAMPLE_MIN: assert property (
    $rose(sample_hold) |-> sample_hold[*4])
    else $error("sample phase too short");
endmodule

bind acr_adc_control_regs acr_adc_control_regs_assertions u_chk
(
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
  .rresp, .rvalid, .rready, .sample_hold, .input_switch,
  .ref_from_bandgap, .bandgap_level
);

// [sim/acr_adc_control_regs_test.sv]
// self-checking bench for the converter control register block
// assumes the front end model and the bound checker are compiled
`include "acr_params.svh"
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("unexpected at %0t got %h exp %h", $time, g, e); \
    end \
  end

module acr_adc_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [2:0] awprot, arprot;
  logic awready, wready, bvalid, arready, rvalid, cmp_above;
  logic [1:0] bresp, rresp, bandgap_level;
  logic [11:0] dac_code, level;
  logic sample_hold, busy, ref_from_bandgap;
  acr_pkg::acr_mux_t input_switch;
  int err_total, checked, run_len, last_len;

  acr_adc_control_regs u_dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .cmp_above, .dac_code, .sample_hold, .busy, .input_switch,
    .ref_from_bandgap, .bandgap_level);
  acr_front_model u_front (.dac_code, .level, .cmp_above);

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // length of the last busy span
  always @(posedge aclk)
  begin
    run_len <= busy ? run_len + 1 : 0;
    if (!busy && run_len != 0)
      last_len <= run_len;
  end

  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic ad, wd;
    int n;
    ad = 0; wd = 0; n = 0; r = 2'h1;
    awaddr <= {20'h0, a}; wdata <= {24'h0, d}; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      if (ad && wd && bvalid)
      begin
        r = bresp;
        break;
      end
      if (!ad && awready) begin ad = 1; awvalid <= 1'b0; end
      if (!wd && wready) begin wd = 1; wvalid <= 1'b0; end
    end
    if (n >= 50) err_total++;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ad;
    int n;
    ad = 0; n = 0; d = 'x; r = 2'h1;
    araddr <= {20'h0, a}; arvalid <= 1'b1; rready <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      if (ad && rvalid)
      begin
        d = rdata; r = rresp;
        break;
      end
      if (!ad && arready) begin ad = 1; arvalid <= 1'b0; end
    end
    if (n >= 50) err_total++;
  endtask

  typedef struct {
    logic [2:0] dv; logic [1:0] rf; logic [4:0] ch; logic [11:0] lv;
  } row_t;
  row_t rows [8] = '{
    '{3'h0, 2'h0, 5'h00, 12'hfff}, '{3'h1, 2'h1, 5'h05, 12'h000},
    '{3'h2, 2'h3, 5'h07, 12'h800}, '{3'h3, 2'h0, 5'h08, 12'h7ff},
    '{3'h4, 2'h0, 5'h0c, 12'ha5c}, '{3'h5, 2'h1, 5'h0e, 12'h001},
    '{3'h6, 2'h3, 5'h17, 12'h3c9}, '{3'h7, 2'h0, 5'h0b, 12'hffe}};

  function automatic logic [14:0] sw_exp(input logic [4:0] c);
    if (c <= 5'h0c) return 15'h4 << c;
    if (c == 5'h0e) return 15'h2;
    if (c == 5'h17) return 15'h1;
    return 15'h0;
  endfunction

  logic [31:0] d;
  logic [1:0] r;
  int d_cyc, k;
  initial
  begin
    aresetn = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
    rready = 0; awaddr = 0; wdata = 0; wstrb = 0; araddr = 0;
    awprot = 0; arprot = 0; level = 0; run_len = 0; last_len = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ACR_ADDR_SELECT, d, r); `CHK(d, 32'h1f)
    rd(`ACR_ADDR_CONTROL, d, r); `CHK(d, 32'h00)
    `CHK(input_switch, 15'h0)
    foreach (rows[i])
    begin
      level <= rows[i].lv;
      wr(`ACR_ADDR_SELECT, {rows[i].rf, 1'b0, rows[i].ch}, 4'h1, r);
      rd(`ACR_ADDR_SELECT, d, r);
      `CHK(d, {24'h0, rows[i].rf, 1'b0, rows[i].ch})
      `CHK(input_switch, sw_exp(rows[i].ch))
      `CHK(ref_from_bandgap, rows[i].rf[0])
      `CHK(bandgap_level, rows[i].rf)
      // near 0.78 mhz in row 0 and 1.56 mhz in row 1
      wr(`ACR_ADDR_CONTROL, {4'h0, 1'b1, rows[i].dv}, 4'h1, r);
      rd(`ACR_ADDR_CONTROL, d, r); `CHK(d[3], 1'b1)
      // poll until the start bit drops
      k = 0;
      while (d[3] === 1'b1 && k < 3000)
      begin
        rd(`ACR_ADDR_CONTROL, d, r);
        k++;
      end
      `CHK(d[3], 1'b0)
      `CHK(d[7:0], {rows[i].lv[3:0], 1'b0, rows[i].dv})
      rd(`ACR_ADDR_RESULT_HIGH, d, r);
      `CHK(d, {24'h0, rows[i].lv[11:4]})
      d_cyc = 256 >> rows[i].dv;
      `CHK(last_len inside {[16*d_cyc - 2 : 16*d_cyc + 6]}, 1'b1)
    end
    // result bytes ignore writes
    wr(`ACR_ADDR_RESULT_HIGH, 8'h00, 4'h1, r);
    rd(`ACR_ADDR_RESULT_HIGH, d, r); `CHK(d, 32'hff)
    wr(`ACR_ADDR_CONTROL, 8'h02, 4'h1, r);
    rd(`ACR_ADDR_CONTROL, d, r); `CHK(d, 32'he2)
    // disabled byte lane leaves the register alone
    wr(`ACR_ADDR_CONTROL, 8'h05, 4'h2, r); `CHK(r, `ACR_RESP_OKAY)
    rd(`ACR_ADDR_CONTROL, d, r); `CHK(d, 32'he2)
    // unmapped place
    wr(12'h068, 8'h0f, 4'h1, r); `CHK(r, `ACR_RESP_SLVERR)
    rd(12'h068, d, r); `CHK(r, `ACR_RESP_SLVERR)
    rd(`ACR_ADDR_SELECT, d, r); `CHK(d, 32'h0b)
    // reset in mid conversion
    wr(`ACR_ADDR_CONTROL, 8'h0f, 4'h1, r);
    repeat (3) @(posedge aclk);
    `CHK(busy, 1'b1)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(busy, 1'b0)
    rd(`ACR_ADDR_CONTROL, d, r); `CHK(d, 32'h00)
    rd(`ACR_ADDR_SELECT, d, r); `CHK(d, 32'h1f)
    // other reserved selector codes switch nothing on
    wr(`ACR_ADDR_SELECT, 8'h0d, 4'h1, r);
    rd(`ACR_ADDR_SELECT, d, r); `CHK(d, 32'h0d)
    `CHK(input_switch, 15'h0)
    tally_and_finish();
  end

  initial
  begin
    repeat (60000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end
endmodule

// [sim/acr_front_model.sv]
// behavioural analog front end: one comparator against a held level
// assumes the bench sets the level before it starts a conversion
module acr_front_model
(
  // converter side
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] level,
  // comparator out
  output logic             cmp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************
  // comparator
  // ****************************************************
  // selected input level
  assign cmp_above = (level >= dac_code);
endmodule
